// file: pkg/dic_pkg.sv
package dic_pkg;
	localparam int unsigned CHANNELS       = 8;
	localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned SCAN_PERIOD_MS = 5;
	localparam int unsigned SCAN_CYCLES    = (CLK_FREQ_HZ / 1000) * SCAN_PERIOD_MS;
	localparam int unsigned AC_DROP_MS     = 30;

	// widths: voltage in mV, thresholds in 0.1 V, delays in ms
	localparam int unsigned VOLT_W  = 19;
	localparam int unsigned THR_W   = 12;
	localparam int unsigned DLY_W   = 21;
	localparam int unsigned CNT_W   = 32;
	localparam int unsigned ADDR_W  = 8;

	localparam logic [VOLT_W-1:0] MV_PER_THR_STEP = 19'h00064;
	localparam logic [VOLT_W-1:0] AC_REL_FACTOR   = 19'h0000A;
	localparam logic [DLY_W-1:0]  SCAN_STEP_MS    = 21'h000005;
	localparam logic [DLY_W-1:0]  AC_EXTRA_MS     = 21'h00001E;
	localparam logic [DLY_W-1:0]  DLY_MAX         = 21'h1FFFFF;

	// per channel block of eight words, channel in addr[7:5]
	localparam int unsigned CH_LSB  = 5;
	localparam int unsigned IDX_LSB = 2;
	localparam logic [2:0] IDX_CTRL    = 3'h0;
	localparam logic [2:0] IDX_ACT_THR = 3'h1;
	localparam logic [2:0] IDX_REL_THR = 3'h2;
	localparam logic [2:0] IDX_ACT_DLY = 3'h3;
	localparam logic [2:0] IDX_DROP_DLY = 3'h4;
	localparam logic [2:0] IDX_COUNTER = 3'h5;
	localparam logic [2:0] IDX_VOLTAGE = 3'h6;
	localparam logic [2:0] IDX_NUMBER  = 3'h7;

	localparam int unsigned CTRL_POL_BIT   = 0;
	localparam int unsigned CTRL_AC_BIT    = 1;
	localparam int unsigned CTRL_CLEAR_BIT = 2;
	localparam int unsigned CTRL_STATE_BIT = 3;

	localparam logic [THR_W-1:0] ACT_THR_RESET = 12'h370;
	localparam logic [THR_W-1:0] REL_THR_RESET = 12'h258;
	localparam logic [DLY_W-1:0] DLY_RESET     = 21'h000000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: sim/dic_checker_assertions.sv
`timescale 1ns/100ps
module dic_checker #(
	parameter int unsigned CHANNELS    = dic_pkg::CHANNELS,
	parameter int unsigned SCAN_CYCLES = dic_pkg::SCAN_CYCLES
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                s_axi_awvalid,
	input  wire logic                s_axi_awready,
	input  wire logic                s_axi_wvalid,
	input  wire logic                s_axi_wready,
	input  wire logic [1:0]          s_axi_bresp,
	input  wire logic                s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic                s_axi_arvalid,
	input  wire logic                s_axi_arready,
	input  wire logic [31:0]         s_axi_rdata,
	input  wire logic [1:0]          s_axi_rresp,
	input  wire logic                s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [CHANNELS-1:0] input_channel_state
);
	// scan phase, restarted by reset together with the scan prescaler
	logic [31:0]         phase_reg;
	logic [31:0]         phase_next;
	logic [CHANNELS-1:0] prev_reg;
	logic [CHANNELS-1:0] prev_next;
	always_comb
	begin
		prev_next  = input_channel_state;
		phase_next = (phase_reg >= SCAN_CYCLES - 1) ? 32'h0 : phase_reg + 32'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase_reg <= 32'h0;
			prev_reg  <= '0;
		end
		else
		begin
			phase_reg <= phase_next;
			prev_reg  <= prev_next;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_blocks_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write address or data accepted while response pending");
	a_read_blocks_ready: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while read data pending");
	a_write_answer_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response not given one cycle after address and data");
	a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not given one cycle after read address");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed before bready");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
		else $error("read data dropped or changed before rready");
	a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated after handshake");
	a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated after handshake");
	a_state_scan_gap: assert property ((input_channel_state != prev_reg) |-> phase_reg == 32'h1)
		else $error("channel state changed between scan instants");
endmodule // dic_checker

bind digital_input_conditioner dic_checker #(.CHANNELS(CHANNELS), .SCAN_CYCLES(SCAN_CYCLES)) i_dic_checker (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.input_channel_state
);

// file: sim/field_wiring.sv
`timescale 1ns/100ps
module field_wiring #(
	parameter int unsigned CHANNELS = dic_pkg::CHANNELS
) (
	input  wire logic                                      aclk,
	input  wire logic [CHANNELS-1:0][dic_pkg::VOLT_W-1:0] set_mv,
	output logic [CHANNELS-1:0][dic_pkg::VOLT_W-1:0]      input_channel_voltage
);
	logic [CHANNELS-1:0][dic_pkg::VOLT_W-1:0] volt_next;
	// wiring lags one cycle; levels beyond the measuring range are clipped
	always_comb
	begin
		for (int i = 0; i < CHANNELS; i++)
			volt_next[i] = (set_mv[i] > 19'h43238) ? 19'h43238 : set_mv[i];
	end
	always_ff @(posedge aclk)
		input_channel_voltage <= volt_next;
endmodule // field_wiring

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam int SC = 20;
	logic                             aclk;
	logic                             aresetn;
	logic [dic_pkg::ADDR_W-1:0]       s_axi_awaddr, s_axi_araddr;
	logic [31:0]                      s_axi_wdata, s_axi_rdata;
	logic [3:0]                       s_axi_wstrb;
	logic [2:0]                       s_axi_awprot, s_axi_arprot;
	logic                             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                             s_axi_rvalid, s_axi_rready;
	logic [1:0]                       s_axi_bresp, s_axi_rresp;
	logic [7:0][dic_pkg::VOLT_W-1:0] set_mv, input_channel_voltage;
	logic [7:0]                       input_channel_state;
	int                               mismatches, checks;

	digital_input_conditioner #(.SCAN_CYCLES(SC)) i_digital_input_conditioner (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .input_channel_voltage, .input_channel_state);
	field_wiring i_field_wiring (.aclk, .set_mv, .input_channel_voltage);

	always #2 aclk = ~aclk;

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic give_up;
		mismatches++;
		$display("ERROR wait bound expected done seen timeout");
		complete_run();
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// lag: edges to wait before raising bready, so a pending response must stand
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, input int lag);
		int n;
		logic ha, hw, hb;
		n = 0;
		hb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		while (!hb)
		begin
			n++;
			if (n > 200)
				give_up();
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
			if (hb)
				s_axi_bready <= 1'b0;
			else if (n >= lag)
				s_axi_bready <= 1'b1;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, input int lag);
		int n;
		logic hr, hd;
		n = 0;
		hd = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		while (!hd)
		begin
			n++;
			if (n > 200)
				give_up();
			@(negedge aclk);
			hr = s_axi_arvalid && s_axi_arready;
			hd = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (hr)
				s_axi_arvalid <= 1'b0;
			if (hd)
				s_axi_rready <= 1'b0;
			else if (n >= lag)
				s_axi_rready <= 1'b1;
		end
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp, input int lag = 0);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r, lag);
		chk(what, exp, d);
		chk("read response", {30'h0, dic_pkg::RESP_OKAY}, {30'h0, r});
	endtask

	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp = dic_pkg::RESP_OKAY,
		input int lag = 0);
		logic [1:0] r;
		wr(a, d, r, lag);
		chk("write response", {30'h0, exp}, {30'h0, r});
	endtask

	task automatic setv(input int ch, input logic [18:0] mv);
		@(posedge aclk);
		set_mv[ch] <= mv;
	endtask

	// state must turn within the k-th scan instant after the change
	task automatic settle(input int ch, input logic v, input int k);
		int el;
		el = 0;
		while (el == 0 || input_channel_state[ch] !== v)
		begin
			if (el > (k + 1) * SC + 10)
				give_up();
			@(negedge aclk);
			el++;
		end
		chk("settle cycles in window", 32'h1, {31'h0, el > (k - 1) * SC && el <= k * SC + 4});
	endtask

	task automatic hold(input int ch, input logic v);
		logic ok;
		ok = 1'b1;
		repeat (3 * SC)
		begin
			@(negedge aclk);
			if (input_channel_state[ch] !== v)
				ok = 1'b0;
		end
		chk("state held", 32'h1, {31'h0, ok});
	endtask

	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		set_mv = '0;
		mismatches = 0;
		checks = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rchk("channel number", {i[2:0], 5'h1C}, i + 1);
		rchk("activation threshold", 8'h04, 32'h370);
		rchk("release threshold", 8'h08, 32'h258);
		rchk("activation delay", 8'h0C, 32'h0);
		rchk("drop-off time", 8'h10, 32'h0);
		rchk("control", 8'h00, 32'h0);
		rchk("counter", 8'h14, 32'h0);
		$display("test reset values done");
		setv(2, 19'h03039);
		rchk("voltage now", 8'h58, 32'h3039);
		$display("test voltage readout done");
		setv(0, 19'h157C0);
		hold(0, 1'b0);
		setv(0, 19'h157C1);
		settle(0, 1'b1, 1);
		chk("state vector", 32'h1, {24'h0, input_channel_state});
		rchk("control state", 8'h00, 32'h8);
		setv(0, 19'h0EA60);
		hold(0, 1'b1);
		setv(0, 19'h0EA5F);
		settle(0, 1'b0, 1);
		rchk("counter", 8'h14, 32'h1);
		wchk(8'h14, 32'h5, dic_pkg::RESP_SLVERR, 3);
		rchk("counter", 8'h14, 32'h1, 3);
		wchk(8'h00, 32'h4);
		rchk("control", 8'h00, 32'h0);
		rchk("counter", 8'h14, 32'h0);
		$display("test thresholds and counter done");
		wchk(8'h20, 32'h1);
		settle(1, 1'b1, 1);
		setv(1, 19'h186A0);
		settle(1, 1'b0, 1);
		$display("test inverted polarity done");
		wchk(8'h6C, 32'h14);
		setv(3, 19'h186A0);
		settle(3, 1'b1, 5);
		wchk(8'h70, 32'hA);
		setv(3, 19'h0);
		settle(3, 1'b0, 3);
		$display("test delays done");
		wchk(8'h80, 32'h2);
		wchk(8'h84, 32'hC8);
		setv(4, 19'h04E21);
		settle(4, 1'b1, 1);
		setv(4, 19'h01388);
		hold(4, 1'b1);
		setv(4, 19'h007CF);
		settle(4, 1'b0, 7);
		rchk("other threshold", 8'h04, 32'h370);
		$display("test alternating supply done");
		// only byte 0 enabled: the upper threshold byte keeps its reset value
		@(posedge aclk);
		s_axi_wstrb <= 4'h1;
		wchk(8'hA4, 32'hABC);
		s_axi_wstrb <= 4'hF;
		rchk("byte-masked threshold", 8'hA4, 32'h3BC);
		$display("test byte strobes done");
		complete_run();
	end
endmodule // testbench

// file: src/channel_conditioner.sv
`timescale 1ns/100ps
module channel_conditioner (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        scan_tick,
	input  wire logic                        polarity,
	input  wire logic                        alternating_supply_mode,
	input  wire logic [dic_pkg::THR_W-1:0]   act_thr,
	input  wire logic [dic_pkg::THR_W-1:0]   rel_thr,
	input  wire logic [dic_pkg::DLY_W-1:0]   act_delay,
	input  wire logic [dic_pkg::DLY_W-1:0]   drop_delay,
	input  wire logic                        clear,
	input  wire logic [dic_pkg::VOLT_W-1:0]  voltage_mv,
	output logic                             state,
	output logic [dic_pkg::CNT_W-1:0]        counter
);
	logic                       comp_reg,  comp_next;
	logic                       state_reg, state_next;
	logic [dic_pkg::DLY_W-1:0]  timer_reg, timer_next;
	logic [dic_pkg::CNT_W-1:0]  cnt_reg,   cnt_next;
	logic [dic_pkg::VOLT_W-1:0] act_mv;
	logic [dic_pkg::VOLT_W-1:0] rel_mv;
	logic [dic_pkg::DLY_W-1:0]  need;
	logic                       raw;

	always_comb
	begin
		act_mv = dic_pkg::VOLT_W'(act_thr) * dic_pkg::MV_PER_THR_STEP;
		rel_mv = alternating_supply_mode ? dic_pkg::VOLT_W'(act_thr) * dic_pkg::AC_REL_FACTOR
		                                 : dic_pkg::VOLT_W'(rel_thr) * dic_pkg::MV_PER_THR_STEP;
		comp_next  = comp_reg;
		state_next = state_reg;
		timer_next = timer_reg;
		if (scan_tick)
		begin
			if (voltage_mv > act_mv)
				comp_next = 1'b1;
			else if (voltage_mv < rel_mv)
				comp_next = 1'b0;
			// between the thresholds the comparator holds
		end
		raw  = comp_next ^ polarity;
		need = act_delay;
		if (!raw)
			need = drop_delay + (alternating_supply_mode ? dic_pkg::AC_EXTRA_MS : dic_pkg::DLY_RESET);
		if (scan_tick)
		begin
			if (raw == state_reg)
				timer_next = dic_pkg::DLY_RESET;
			else if (timer_reg >= need)
			begin
				state_next = raw;
				timer_next = dic_pkg::DLY_RESET;
			end
			else if (timer_reg <= dic_pkg::DLY_MAX - dic_pkg::SCAN_STEP_MS)
				timer_next = timer_reg + dic_pkg::SCAN_STEP_MS;
		end
		// a rising edge in the clear cycle still counts
		cnt_next = clear ? '0 : cnt_reg;
		if (state_next && !state_reg)
			cnt_next = cnt_next + 32'h00000001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			comp_reg  <= 1'b0;
			state_reg <= 1'b0;
			timer_reg <= '0;
			cnt_reg   <= '0;
		end
		else
		begin
			comp_reg  <= comp_next;
			state_reg <= state_next;
			timer_reg <= timer_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign state   = state_reg;
	assign counter = cnt_reg;
endmodule // channel_conditioner

// file: src/digital_input_conditioner.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
// Contract
// - Eight independent channels, numbered after channels of preceding modules.
// - Channel state is re-evaluated only at each 5 ms scan tick.
// - Polarity setting: 0 normally-open, 1 normally-closed; default normally-open.
// - Voltage above activation threshold activates (NO) or deactivates (NC); default 88 V.
// - Voltage below release threshold deactivates (NO) or activates (NC); default 60 V.
// - Rising change of reported state waits the activation delay in ms.
// - Falling change of reported state waits the drop-off time in ms.
// - Alternating supply mode adds a fixed 30 ms deactivation delay.
// - In alternating supply mode release threshold is 10 % of activation threshold.
// - Per-channel 32-bit counter of state rising edges, reset to zero.
// - Writing 1 to clear control zeros the counter; control reads as zero.
// - All settings are held separately for each channel.
// - Each channel's measured voltage is readable with 1 mV resolution.
module digital_input_conditioner #(
	parameter int unsigned CHANNELS     = dic_pkg::CHANNELS,
	parameter int unsigned SCAN_CYCLES  = dic_pkg::SCAN_CYCLES,
	parameter int unsigned CHANNEL_BASE = 0
) (
	input  wire logic                                aclk,
	input  wire logic                                aresetn,
	input  wire logic [dic_pkg::ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic [2:0]                          s_axi_awprot,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	input  wire logic [dic_pkg::ADDR_W-1:0]          s_axi_araddr,
	input  wire logic [2:0]                          s_axi_arprot,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	output logic [31:0]                              s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	input  wire logic [CHANNELS-1:0][dic_pkg::VOLT_W-1:0] input_channel_voltage,
	output logic [CHANNELS-1:0]                      input_channel_state
);
	function automatic logic [2:0] chan_of(input logic [dic_pkg::ADDR_W-1:0] a);
		chan_of = a[dic_pkg::CH_LSB +: 3];
	endfunction

	function automatic logic [2:0] idx_of(input logic [dic_pkg::ADDR_W-1:0] a);
		idx_of = a[dic_pkg::IDX_LSB +: 3];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		merge = r;
	endfunction

	logic                        scan_tick;
	logic [CHANNELS-1:0]         pol_reg,  pol_next;
	logic [CHANNELS-1:0]         ac_reg,   ac_next;
	logic [CHANNELS-1:0]         clr_reg,  clr_next;
	logic [dic_pkg::THR_W-1:0]   act_thr_reg  [CHANNELS];
	logic [dic_pkg::THR_W-1:0]   act_thr_next [CHANNELS];
	logic [dic_pkg::THR_W-1:0]   rel_thr_reg  [CHANNELS];
	logic [dic_pkg::THR_W-1:0]   rel_thr_next [CHANNELS];
	logic [dic_pkg::DLY_W-1:0]   act_dly_reg  [CHANNELS];
	logic [dic_pkg::DLY_W-1:0]   act_dly_next [CHANNELS];
	logic [dic_pkg::DLY_W-1:0]   drop_dly_reg [CHANNELS];
	logic [dic_pkg::DLY_W-1:0]   drop_dly_next[CHANNELS];
	logic [dic_pkg::CNT_W-1:0]   counter      [CHANNELS];

	logic                        aw_got_reg, aw_got_next;
	logic                        w_got_reg,  w_got_next;
	logic [dic_pkg::ADDR_W-1:0]  awaddr_reg, awaddr_next;
	logic [31:0]                 wdata_reg,  wdata_next;
	logic [3:0]                  wstrb_reg,  wstrb_next;
	logic                        bvalid_reg, bvalid_next;
	logic [1:0]                  bresp_reg,  bresp_next;
	logic                        rvalid_reg, rvalid_next;
	logic [1:0]                  rresp_reg,  rresp_next;
	logic [31:0]                 rdata_reg,  rdata_next;

	logic                        do_write;
	logic [dic_pkg::ADDR_W-1:0]  wa;
	logic [31:0]                 wd;
	logic [3:0]                  ws;
	logic [2:0]                  wch;
	logic [2:0]                  rch;

	scan_tick_gen #(
		.SCAN_CYCLES (SCAN_CYCLES)
	) u_scan (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.scan_tick (scan_tick)
	);

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_chan
			channel_conditioner u_chan (
				.aclk                    (aclk),
				.aresetn                 (aresetn),
				.scan_tick               (scan_tick),
				.polarity                (pol_reg[g]),
				.alternating_supply_mode (ac_reg[g]),
				.act_thr                 (act_thr_reg[g]),
				.rel_thr                 (rel_thr_reg[g]),
				.act_delay               (act_dly_reg[g]),
				.drop_delay              (drop_dly_reg[g]),
				.clear                   (clr_reg[g]),
				.voltage_mv              (input_channel_voltage[g]),
				.state                   (input_channel_state[g]),
				.counter                 (counter[g])
			);
		end
	endgenerate

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready  = !w_got_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;

	// write channel: address and data taken in either order
	always_comb
	begin
		aw_got_next = aw_got_reg;
		w_got_next  = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next  = wdata_reg;
		wstrb_next  = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		do_write = aw_got_next && w_got_next && !bvalid_reg;
		wa  = awaddr_next;
		wd  = wdata_next;
		ws  = wstrb_next;
		wch = chan_of(wa);
		if (do_write)
		begin
			aw_got_next = 1'b0;
			w_got_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = (32'(wch) < CHANNELS && idx_of(wa) <= dic_pkg::IDX_DROP_DLY)
			              ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
	end

	// settings registers
	always_comb
	begin
		logic [31:0] tmp;
		tmp      = 32'h00000000;
		pol_next = pol_reg;
		ac_next  = ac_reg;
		clr_next = '0;
		for (int c = 0; c < CHANNELS; c++)
		begin
			act_thr_next[c]  = act_thr_reg[c];
			rel_thr_next[c]  = rel_thr_reg[c];
			act_dly_next[c]  = act_dly_reg[c];
			drop_dly_next[c] = drop_dly_reg[c];
		end
		if (do_write && 32'(wch) < CHANNELS)
		begin
			case (idx_of(wa))
				dic_pkg::IDX_CTRL:
				begin
					if (ws[0])
					begin
						pol_next[wch] = wd[dic_pkg::CTRL_POL_BIT];
						ac_next[wch]  = wd[dic_pkg::CTRL_AC_BIT];
						clr_next[wch] = wd[dic_pkg::CTRL_CLEAR_BIT];
					end
				end
				dic_pkg::IDX_ACT_THR:
				begin
					tmp = merge(32'(act_thr_reg[wch]), wd, ws);
					act_thr_next[wch] = tmp[dic_pkg::THR_W-1:0];
				end
				dic_pkg::IDX_REL_THR:
				begin
					tmp = merge(32'(rel_thr_reg[wch]), wd, ws);
					rel_thr_next[wch] = tmp[dic_pkg::THR_W-1:0];
				end
				dic_pkg::IDX_ACT_DLY:
				begin
					tmp = merge(32'(act_dly_reg[wch]), wd, ws);
					act_dly_next[wch] = tmp[dic_pkg::DLY_W-1:0];
				end
				dic_pkg::IDX_DROP_DLY:
				begin
					tmp = merge(32'(drop_dly_reg[wch]), wd, ws);
					drop_dly_next[wch] = tmp[dic_pkg::DLY_W-1:0];
				end
				default:
				begin
					tmp = 32'h00000000;
				end
			endcase
		end
	end

	// read channel
	always_comb
	begin
		rvalid_next = rvalid_reg;
		rresp_next  = rresp_reg;
		rdata_next  = rdata_reg;
		rch         = chan_of(s_axi_araddr);
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next  = dic_pkg::RESP_OKAY;
			rdata_next  = 32'h00000000;
			if (32'(rch) >= CHANNELS)
				rresp_next = dic_pkg::RESP_SLVERR;
			else
			begin
				case (idx_of(s_axi_araddr))
					dic_pkg::IDX_CTRL:
					begin
						// clear bit always reads zero
						rdata_next[dic_pkg::CTRL_POL_BIT]   = pol_reg[rch];
						rdata_next[dic_pkg::CTRL_AC_BIT]    = ac_reg[rch];
						rdata_next[dic_pkg::CTRL_STATE_BIT] = input_channel_state[rch];
					end
					dic_pkg::IDX_ACT_THR:  rdata_next = 32'(act_thr_reg[rch]);
					dic_pkg::IDX_REL_THR:  rdata_next = 32'(rel_thr_reg[rch]);
					dic_pkg::IDX_ACT_DLY:  rdata_next = 32'(act_dly_reg[rch]);
					dic_pkg::IDX_DROP_DLY: rdata_next = 32'(drop_dly_reg[rch]);
					dic_pkg::IDX_COUNTER:  rdata_next = counter[rch];
					dic_pkg::IDX_VOLTAGE:  rdata_next = 32'(input_channel_voltage[rch]);
					dic_pkg::IDX_NUMBER:   rdata_next = 32'(CHANNEL_BASE) + 32'(rch) + 32'h00000001;
					default:               rdata_next = 32'h00000000;
				endcase
			end
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg  <= 32'h00000000;
			wstrb_reg  <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= dic_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg  <= dic_pkg::RESP_OKAY;
			rdata_reg  <= 32'h00000000;
			pol_reg    <= '0;
			ac_reg     <= '0;
			clr_reg    <= '0;
			for (int c = 0; c < CHANNELS; c++)
			begin
				act_thr_reg[c]  <= dic_pkg::ACT_THR_RESET;
				rel_thr_reg[c]  <= dic_pkg::REL_THR_RESET;
				act_dly_reg[c]  <= dic_pkg::DLY_RESET;
				drop_dly_reg[c] <= dic_pkg::DLY_RESET;
			end
		end
		else
		begin
			aw_got_reg <= aw_got_next;
			w_got_reg  <= w_got_next;
			awaddr_reg <= awaddr_next;
			wdata_reg  <= wdata_next;
			wstrb_reg  <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg  <= rresp_next;
			rdata_reg  <= rdata_next;
			pol_reg    <= pol_next;
			ac_reg     <= ac_next;
			clr_reg    <= clr_next;
			for (int c = 0; c < CHANNELS; c++)
			begin
				act_thr_reg[c]  <= act_thr_next[c];
				rel_thr_reg[c]  <= rel_thr_next[c];
				act_dly_reg[c]  <= act_dly_next[c];
				drop_dly_reg[c] <= drop_dly_next[c];
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;
endmodule // digital_input_conditioner

// file: src/scan_tick_gen.sv
`timescale 1ns/100ps
module scan_tick_gen #(
	parameter int unsigned SCAN_CYCLES = dic_pkg::SCAN_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      scan_tick
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic        tick_reg;
	logic        tick_next;

	always_comb
	begin
		tick_next  = 1'b0;
		count_next = count_reg + 32'h00000001;
		if (count_reg >= 32'(SCAN_CYCLES - 1))
		begin
			count_next = 32'h00000000;
			tick_next  = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_reg <= 32'h00000000;
			tick_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign scan_tick = tick_reg;
endmodule // scan_tick_gen
